// ===== hdl/gauge_cfg_pkg.sv
// constants for the nonvolatile configuration bank of the fuel gauge
// assumes a single 25 MHz clock and a byte-wide register port
package gauge_cfg_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] OFS_INITIAL_CAPACITY_HIGH_BYTE = 7'h76;
    localparam logic [6:0] OFS_EMPTY_VOLTAGE_THRESHOLD = 7'h77;
    localparam logic [6:0] OFS_LOW_WARNING_VOLTAGE_THRESHOLD = 7'h78;
    localparam logic [6:0] OFS_INITIAL_STANDBY_CURRENT = 7'h79;
    localparam logic [6:0] OFS_FILTER_AND_SELF_DISCHARGE = 7'h7a;
    localparam logic [6:0] OFS_AGING_AND_TAPER = 7'h7b;
    localparam logic [6:0] OFS_PACK_CONFIGURATION = 7'h7c;
    localparam logic [6:0] OFS_INITIAL_MAX_LOAD_CURRENT = 7'h7d;
    localparam logic [6:0] OFS_DISCHARGE_RATE_COMP = 7'h7e;
    localparam logic [6:0] OFS_TEMPERATURE_COMP = 7'h7f;
    localparam logic [6:0] OFS_NV_WRITE_UNLOCK = 7'h6e;
    localparam logic [6:0] OFS_MODE = 7'h00;
    localparam int NV_BYTES = 10;
    localparam logic [7:0] NV_WRITE_UNLOCK_KEY = 8'hdd;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PK_GPIO_EN_BIT = 7;
    localparam int PK_QV_HI = 6;
    localparam int PK_QV_LO = 5;
    localparam int PK_BOARD_OFFSET_CODE_HI = 4;
    localparam int PK_BOARD_OFFSET_CODE_LO = 2;
    localparam int PK_FIXED_DISCHARGE_COMP_SEL_BIT = 1;
    localparam int PK_FIXED_TEMPERATURE_COMP_SEL_BIT = 0;
    localparam int TAPER_AGING_BIT = 7;
    localparam int MODE_GPIO_EN_BIT = 7;
    localparam int MODE_GPIO_LEVEL_BIT = 6;
    // ------------------------------------------------------------
    // fixed values and scaling
    // ------------------------------------------------------------
    localparam logic [7:0] FIXED_DISCHARGE_RATE_COMPENSATION = 8'h42;
    localparam logic [7:0] FIXED_TEMPERATURE_COMPENSATION = 8'h7c;
    localparam logic [15:0] QV_MV_00 = 16'd3968;
    localparam logic [15:0] QV_MV_01 = 16'd4016;
    localparam logic [15:0] QV_MV_10 = 16'd4064;
    localparam logic [15:0] QV_MV_11 = 16'd4112;
    localparam int SELF_DIS_SHIFT = 9;
    localparam int AGING_SHIFT = 10;
    localparam int WARN_REMAIN_SHIFT = 4;
    localparam logic [2:0] AGE_SD_STEPS = 3'd7;
    localparam int TEMP_BANDS = 7;
    localparam logic [2:0] TEMP_BAND_NOMINAL = 3'd2;
    // ------------------------------------------------------------
    // load sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_INIT = 2'b11,
        ST_RUN = 2'b10
    } load_state_t;
endpackage

// ===== hdl/gauge_config_nv_bank.sv
// configuration bank: nonvolatile bytes, init load, learning and aging
// assumes nv storage answers reads one cycle after the address
`timescale 1ns/1ps
module gauge_config_nv_bank
    import gauge_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // nonvolatile storage
    output logic [3:0] nv_addr,
    input wire logic [7:0] nv_rdata,
    output logic nv_we,
    output logic [7:0] nv_wdata,
    // gauge measurements
    input wire logic tick,
    input wire logic charging,
    input wire logic discharge_valid,
    input wire logic warning_voltage_level,
    input wire logic [15:0] avg_current,
    input wire logic [15:0] battery_mv,
    input wire logic [2:0] temp_band,
    input wire logic cycle_inc,
    input wire logic [3:0] internal_offset,
    // gpio pin
    input wire logic gpio_in,
    output logic gpio_oe_n,
    // results
    output logic ready,
    output logic [15:0] learned_full_capacity,
    output logic [15:0] nominal_available_charge,
    output logic [15:0] standby_current,
    output logic learn_disqualified,
    output logic charge_full,
    output logic [15:0] qual_voltage_mv,
    output logic [3:0] offset_total,
    output logic [7:0] discharge_rate_compensation_active,
    output logic [7:0] temperature_compensation_active,
    output logic [3:0] magnitude_filter_threshold,
    output logic [3:0] self_discharge_rate_code
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] cfg [NV_BYTES];
    load_state_t state;
    logic [3:0] load_idx;
    logic unlocked;
    logic gpio_input_enable;
    logic [15:0] sd_timer;
    logic [2:0] sd_steps;
    logic cycle_half;

    function automatic logic [3:0] cfg_index(input logic [6:0] a);
        return 4'(a - OFS_INITIAL_CAPACITY_HIGH_BYTE);
    endfunction

    function automatic logic cfg_hit(input logic [6:0] a);
        return a >= OFS_INITIAL_CAPACITY_HIGH_BYTE && a <= OFS_TEMPERATURE_COMP;
    endfunction

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    wire [7:0] pack_configuration = cfg[cfg_index(OFS_PACK_CONFIGURATION)];
    wire [7:0] taper = cfg[cfg_index(OFS_AGING_AND_TAPER)];
    wire [7:0] filter_and_self_discharge_config = cfg[cfg_index(OFS_FILTER_AND_SELF_DISCHARGE)];
    wire [7:0] initial_standby_current = cfg[cfg_index(OFS_INITIAL_STANDBY_CURRENT)];
    wire [7:0] initial_capacity_high_byte = cfg[cfg_index(OFS_INITIAL_CAPACITY_HIGH_BYTE)];
    wire [15:0] design_cap = {initial_capacity_high_byte, 8'h00};
    wire [15:0] initial_standby_current_twice = {7'h00, initial_standby_current, 1'b0};
    wire aging_en = taper[TAPER_AGING_BIT];
    wire [6:0] taper_cur = taper[6:0];
    wire [1:0] qv_sel = {pack_configuration[PK_QV_HI], pack_configuration[PK_QV_LO]};
    wire [2:0] board_offset_code = pack_configuration[PK_BOARD_OFFSET_CODE_HI:PK_BOARD_OFFSET_CODE_LO];
    wire running = state == ST_RUN;
    wire write_hit = reg_wr && cfg_hit(reg_addr) && unlocked && running;
    wire unlock_hit = reg_wr && reg_addr == OFS_NV_WRITE_UNLOCK;
    // sd period shrinks warmer, grows colder; band 2 is 20-30 C
    wire [15:0] sd_base = {8'h00, filter_and_self_discharge_config[3:0], 4'h0} + 16'h0001;
    wire [15:0] sd_period = temp_band >= TEMP_BAND_NOMINAL
        ? sd_base >> (temp_band - TEMP_BAND_NOMINAL)
        : sd_base << (TEMP_BAND_NOMINAL - temp_band);
    // due on the tick that completes the period, this tick counted
    wire sd_due = tick && !charging && sd_timer + 16'h0001 >= sd_period && running;
    wire [15:0] next_nac_sd = nominal_available_charge
        - (nominal_available_charge >> SELF_DIS_SHIFT);
    wire age_cycle = aging_en && cycle_inc && cycle_half;
    wire age_sd = aging_en && sd_due && sd_steps == AGE_SD_STEPS;
    wire [15:0] age_step = design_cap >> AGING_SHIFT;
    wire [15:0] next_cap_aged = learned_full_capacity > age_step
        ? learned_full_capacity - age_step : 16'h0000;
    wire learn_ok = avg_current > initial_standby_current_twice;
    wire learn_now = running && discharge_valid && warning_voltage_level && learn_ok;
    wire [15:0] learned_cap = (design_cap - nominal_available_charge)
        + ((design_cap - nominal_available_charge) >> WARN_REMAIN_SHIFT);
    wire standby_upd = tick && running && avg_current[15:4] > {8'h00, filter_and_self_discharge_config[7:4]}
        && avg_current <= initial_standby_current_twice;
    wire [15:0] next_standby = standby_current - (standby_current >> 4)
        + (avg_current >> 4);
    wire [15:0] next_qv = qv_sel == 2'b00 ? QV_MV_00
        : qv_sel == 2'b01 ? QV_MV_01
        : qv_sel == 2'b10 ? QV_MV_10 : QV_MV_11;
    wire [7:0] mode_byte = {gpio_input_enable, gpio_input_enable & gpio_in, 6'h00};
    wire [7:0] next_rdata = cfg_hit(reg_addr) ? cfg[cfg_index(reg_addr)]
        : reg_addr == OFS_MODE ? mode_byte : 8'h00;

    // ------------------------------------------------------------
    // load sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            load_idx <= 4'h0;
        end else begin
            unique case (state)
                ST_IDLE: state <= ST_LOAD;
                ST_LOAD: begin
                    load_idx <= load_idx + 4'h1;
                    if (load_idx == 4'(NV_BYTES - 1)) state <= ST_INIT;
                end
                ST_INIT: state <= ST_RUN;
                ST_RUN: state <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration bytes
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NV_BYTES; i++) cfg[i] <= 8'h00;
        end else if (state == ST_LOAD) begin
            cfg[load_idx] <= nv_rdata;
        end else if (write_hit) begin
            cfg[cfg_index(reg_addr)] <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unlocked <= 1'b0;
            nv_addr <= 4'h0;
            nv_we <= 1'b0;
            nv_wdata <= 8'h00;
            reg_rdata <= 8'h00;
        end else begin
            if (unlock_hit) unlocked <= reg_wdata == NV_WRITE_UNLOCK_KEY;
            nv_addr <= write_hit ? cfg_index(reg_addr)
                : state == ST_IDLE ? 4'h0 : load_idx + 4'h1;
            nv_we <= write_hit;
            nv_wdata <= reg_wdata;
            if (reg_rd) reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // gauge working state
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            learned_full_capacity <= 16'h0000;
            nominal_available_charge <= 16'h0000;
            standby_current <= 16'h0000;
            gpio_input_enable <= 1'b0;
            learn_disqualified <= 1'b0;
            sd_timer <= 16'h0000;
            sd_steps <= 3'd0;
            cycle_half <= 1'b0;
        end else if (state == ST_INIT) begin
            learned_full_capacity <= design_cap;
            nominal_available_charge <= design_cap;
            standby_current <= {8'h00, initial_standby_current};
            gpio_input_enable <= pack_configuration[PK_GPIO_EN_BIT];
        end else if (running) begin
            if (learn_now) learned_full_capacity <= learned_cap;
            else if (age_cycle || age_sd) learned_full_capacity <= next_cap_aged;
            if (warning_voltage_level && discharge_valid) learn_disqualified <= !learn_ok;
            if (sd_due) nominal_available_charge <= next_nac_sd;
            if (standby_upd) standby_current <= next_standby;
            if (sd_due) sd_timer <= 16'h0000;
            else if (tick && !charging) sd_timer <= sd_timer + 16'h0001;
            if (charge_full) sd_steps <= 3'd0;
            else if (sd_due) sd_steps <= sd_steps + 3'd1;
            if (cycle_inc) cycle_half <= !cycle_half;
        end
    end

    // ------------------------------------------------------------
    // derived outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready <= 1'b0;
            gpio_oe_n <= 1'b1;
            charge_full <= 1'b0;
            qual_voltage_mv <= QV_MV_00;
            offset_total <= 4'h0;
            discharge_rate_compensation_active <= 8'h00;
            temperature_compensation_active <= 8'h00;
            magnitude_filter_threshold <= 4'h0;
            self_discharge_rate_code <= 4'h0;
        end else begin
            ready <= running;
            gpio_oe_n <= 1'b1;
            charge_full <= charging && battery_mv >= next_qv
                && avg_current < {9'h000, taper_cur};
            qual_voltage_mv <= next_qv;
            offset_total <= internal_offset + {board_offset_code[2], board_offset_code};
            discharge_rate_compensation_active <= pack_configuration[PK_FIXED_DISCHARGE_COMP_SEL_BIT] ? FIXED_DISCHARGE_RATE_COMPENSATION
                : cfg[cfg_index(OFS_DISCHARGE_RATE_COMP)];
            temperature_compensation_active <= pack_configuration[PK_FIXED_TEMPERATURE_COMP_SEL_BIT] ? FIXED_TEMPERATURE_COMPENSATION
                : cfg[cfg_index(OFS_TEMPERATURE_COMP)];
            magnitude_filter_threshold <= filter_and_self_discharge_config[7:4];
            self_discharge_rate_code <= filter_and_self_discharge_config[3:0];
        end
    end
endmodule

// ===== tb/gauge_cfg_assertions.sv
// assertions on the configuration bank ports
// assumes binding onto every gauge_config_nv_bank instance
`timescale 1ns/1ps
module gauge_cfg_assertions
    import gauge_cfg_pkg::*;
(
    // clock, reset and register port
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    // gauge inputs
    input wire logic charging,
    input wire logic [3:0] internal_offset,
    // results
    input wire logic gpio_oe_n,
    input wire logic ready,
    input wire logic [15:0] learned_full_capacity,
    input wire logic [15:0] nominal_available_charge,
    input wire logic [15:0] qual_voltage_mv,
    input wire logic [3:0] offset_total,
    input wire logic [7:0] discharge_rate_compensation_active,
    input wire logic [7:0] temperature_compensation_active,
    input wire logic [3:0] magnitude_filter_threshold,
    input wire logic [3:0] self_discharge_rate_code
);
    localparam logic [15:0] QV_TAB [4] = '{QV_MV_00, QV_MV_01, QV_MV_10, QV_MV_11};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_gpio_never_driven: assert property (gpio_oe_n)
        else $error("gpio pin driven");
    a_ready_after_load: assert property ($fell(rst) |-> ##[1:20] ready)
        else $error("config never loaded");
    a_init_capacity_low: assert property ($rose(ready) |-> learned_full_capacity[7:0] == 8'h00
        && nominal_available_charge == learned_full_capacity)
        else $error("initial capacity wrong");
    a_no_drop_charging: assert property (ready && $past(ready) && $past(charging)
        |-> nominal_available_charge >= $past(nominal_available_charge))
        else $error("charge reduced while charging");
    a_sd_step_size: assert property (ready && $past(ready)
        && nominal_available_charge < $past(nominal_available_charge)
        |-> nominal_available_charge == $past(nominal_available_charge)
        - ($past(nominal_available_charge) >> SELF_DIS_SHIFT))
        else $error("self-discharge step size wrong");
    a_field_split: assert property ($past(reg_rd) && $past(reg_addr) == OFS_FILTER_AND_SELF_DISCHARGE
        |-> reg_rdata == {magnitude_filter_threshold, self_discharge_rate_code})
        else $error("filter fields misplaced");
    a_fixed_discharge_rate_compensation_sel: assert property ($past(reg_rd) && $past(reg_addr) == OFS_PACK_CONFIGURATION
        && reg_rdata[PK_FIXED_DISCHARGE_COMP_SEL_BIT] |-> discharge_rate_compensation_active == FIXED_DISCHARGE_RATE_COMPENSATION)
        else $error("fixed discharge comp missing");
    a_fixed_temperature_compensation_sel: assert property ($past(reg_rd) && $past(reg_addr) == OFS_PACK_CONFIGURATION
        && reg_rdata[PK_FIXED_TEMPERATURE_COMP_SEL_BIT] |-> temperature_compensation_active == FIXED_TEMPERATURE_COMPENSATION)
        else $error("fixed temperature comp missing");
    a_qual_voltage_map: assert property ($past(reg_rd) && $past(reg_addr) == OFS_PACK_CONFIGURATION
        |-> qual_voltage_mv == QV_TAB[reg_rdata[6:5]])
        else $error("qualification voltage wrong");
    a_offset_sum: assert property ($past(reg_rd) && $past(reg_addr) == OFS_PACK_CONFIGURATION
        |-> offset_total == internal_offset + {reg_rdata[4], reg_rdata[4:2]})
        else $error("offset sum wrong");
endmodule
bind gauge_config_nv_bank gauge_cfg_assertions chk (.*);

// ===== tb/gauge_config_nv_bank_bench.sv
// self-checking bench for the configuration bank
// assumes package, bank and checker compiled before it
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end
module gauge_config_nv_bank_bench;
    import gauge_cfg_pkg::*;
    logic clk, rst, reg_wr, reg_rd, tick, charging, discharge_valid, warning_voltage_level;
    logic cycle_inc, gpio_in, nv_we, gpio_oe_n, ready, learn_disqualified, charge_full;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, nv_rdata, nv_wdata, discharge_rate_compensation_active, temperature_compensation_active, pk;
    logic [3:0] nv_addr, internal_offset, offset_total;
    logic [3:0] magnitude_filter_threshold, self_discharge_rate_code;
    logic [2:0] temp_band;
    logic [15:0] avg_current, battery_mv, learned_full_capacity, nominal_available_charge;
    logic [15:0] standby_current, qual_voltage_mv, e, cap, nv;
    logic [7:0] mem [16];
    logic [7:0] shadow [10];
    logic [15:0] expq [$];
    logic [31:0] seed = 32'h9ad7;
    logic pend = 0;
    int miscompares = 0, comparisons = 0, cyc = 0;
    gauge_config_nv_bank DUT (.*);
    // ------------------------------------------------------------
    // clock, storage model, read watcher
    // ------------------------------------------------------------
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pend <= reg_rd;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    always @(negedge clk) begin
        nv_rdata <= mem[nv_addr];
        if (nv_we) mem[nv_addr] <= nv_wdata;
        if (pend) begin
            e = expq.pop_front();
            `CHK("read data", e[7:0], reg_rdata & e[15:8])
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        expq.push_back({m, x & m});
        @(negedge clk);
        reg_rd = 0;
    endtask
    task automatic pulse(input int n, input bit ci);
        repeat (n) begin
            @(negedge clk);
            {tick, cycle_inc} = {!ci, ci};
            @(negedge clk);
            {tick, cycle_inc} = 2'b00;
            repeat (3) @(negedge clk);
        end
    endtask
    task automatic do_reset();
        rst = 1;
        repeat (5) @(negedge clk);
        rst = 0;
        repeat (40) if (!ready) @(negedge clk);
        `CHK("ready", 1'b1, ready)
    endtask
    task automatic stop_test();
        $display("counts: %0d compared, %0d bad", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {rst, reg_wr, reg_rd, tick, charging, discharge_valid, warning_voltage_level} = 7'h40;
        {cycle_inc, reg_addr, reg_wdata, nv_rdata, avg_current, battery_mv} = 0;
        {temp_band, gpio_in, internal_offset} = {TEMP_BAND_NOMINAL, 1'b1, 4'(rnd())};
        for (int i = 0; i < 16; i++) mem[i] = 8'(rnd());
        mem[0] = mem[0] | 8'h80;
        mem[6] = 8'h80;
        for (int i = 0; i < 10; i++) shadow[i] = mem[i];
        do_reset();
        `CHK("capacity", {mem[0], 8'h00}, learned_full_capacity)
        `CHK("standby", {8'h00, mem[3]}, standby_current)
        `CHK("filter", mem[4], {magnitude_filter_threshold, self_discharge_rate_code})
        `CHK("discharge_rate_compensation", mem[8], discharge_rate_compensation_active)
        `CHK("temperature_compensation", mem[9], temperature_compensation_active)
        for (int i = 0; i < 10; i++) rd(7'h76 + 7'(i), shadow[i]);
        rd(OFS_MODE, 8'hc0, 8'hc0);
        gpio_in = 0;
        repeat (4) @(negedge clk);
        rd(OFS_MODE, 8'h80, 8'hc0);
        rd(7'h30, 8'h00);
        $display("init test done");
        wr(OFS_PACK_CONFIGURATION, 8'h00);
        rd(OFS_PACK_CONFIGURATION, shadow[6]);
        wr(OFS_NV_WRITE_UNLOCK, NV_WRITE_UNLOCK_KEY);
        for (int i = 0; i < 8; i++) begin
            pk = {1'b1, 2'(i), 3'(i), i[0], i[1]};
            wr(OFS_PACK_CONFIGURATION, pk);
            shadow[6] = pk;
            rd(OFS_PACK_CONFIGURATION, pk);
            `CHK("qual mv", 16'd3968 + 16'(48 * (i % 4)), qual_voltage_mv)
            `CHK("offset", internal_offset + {pk[4], pk[4:2]}, offset_total)
            `CHK("discharge_rate_compensation sel", pk[1] ? FIXED_DISCHARGE_RATE_COMPENSATION : shadow[8], discharge_rate_compensation_active)
            `CHK("temperature_compensation sel", pk[0] ? FIXED_TEMPERATURE_COMPENSATION : shadow[9], temperature_compensation_active)
        end
        for (int i = 1; i < 10; i++) if (i != 6) begin
            shadow[i] = 8'(rnd());
            wr(7'h76 + 7'(i), shadow[i]);
        end
        wr(OFS_NV_WRITE_UNLOCK, 8'h00);
        wr(OFS_EMPTY_VOLTAGE_THRESHOLD, ~shadow[1]);
        for (int i = 0; i < 10; i++) rd(7'h76 + 7'(i), shadow[i]);
        for (int i = 0; i < 10; i++) `CHK("stored", shadow[i], mem[i])
        $display("lock test done");
        wr(OFS_NV_WRITE_UNLOCK, NV_WRITE_UNLOCK_KEY);
        wr(OFS_AGING_AND_TAPER, 8'h00);
        wr(OFS_FILTER_AND_SELF_DISCHARGE, 8'h00);
        {cap, nv, charging} = {{shadow[0], 8'h00}, {shadow[0], 8'h00}, 1'b1};
        pulse(20, 0);
        `CHK("held charge", nv, nominal_available_charge)
        charging = 0;
        pulse(4, 0);
        repeat (4) nv = nv - (nv >> 9);
        `CHK("self discharge", nv, nominal_available_charge)
        charging = 1;
        for (int a = 0; a < 2; a++) begin
            wr(OFS_AGING_AND_TAPER, {a[0], 7'h00});
            pulse(2, 1);
            cap = cap - (a[0] ? 16'(shadow[0] >> 2) : 16'h0);
            `CHK("aging", cap, learned_full_capacity)
        end
        wr(OFS_FILTER_AND_SELF_DISCHARGE, 8'h0f);
        {charging, discharge_valid, warning_voltage_level} = 3'b011;
        avg_current = 16'(2 * shadow[3]);
        pulse(1, 0);
        `CHK("disqualified", 1'b1, learn_disqualified)
        avg_current = avg_current + 16'h1;
        pulse(1, 0);
        `CHK("learned", 16'((32'({shadow[0], 8'h00} - nv) * 17) >> 4), learned_full_capacity)
        {discharge_valid, warning_voltage_level} = 2'b00;
        {charging, battery_mv, avg_current} = {1'b1, 16'd4200, 16'h0000};
        wr(OFS_AGING_AND_TAPER, 8'h7f);
        @(negedge clk);
        `CHK("full", 1'b1, charge_full)
        $display("gauge test done");
        wr(OFS_PACK_CONFIGURATION, 8'h00);
        do_reset();
        rd(OFS_MODE, 8'h00, 8'h80);
        `CHK("capacity again", {shadow[0], 8'h00}, learned_full_capacity)
        repeat (4) @(negedge clk);
        $display("reset test done");
        stop_test();
    end
endmodule
